// ---- pfd_pkg.sv ----
package pfd_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_OPERATIONS = 8'h02;
   localparam logic [7:0] IDX_DOC_THRESH = 8'h0B;
   localparam logic [7:0] IDX_DELAY = 8'h0D;
   localparam logic [7:0] IDX_CONNECT = 8'h0E;
   localparam logic [7:0] IDX_COC_THRESH = 8'h0F;
   localparam logic [7:0] IDX_SUPPLY_MIN = 8'h1C;
   localparam logic [7:0] IDX_REG_ACTIVE = 8'h1D;
   localparam logic [7:0] IDX_REG_SLEEP = 8'h1E;
   localparam logic [7:0] IDX_PUMP_CTRL = 8'h24;
   localparam logic [7:0] IDX_FAULTS = 8'h63;
   localparam logic [7:0] IDX_STATUS = 8'h65;
   localparam logic [7:0] IDX_INDICATORS = 8'h67;
   localparam logic [7:0] IDX_TRANSISTORS = 8'h70;
   // field positions
   localparam int BIT_CLEAR_FAULTS = 1;
   localparam int BIT_DOC_CONNECT = 7;
   localparam int BIT_COC_CONNECT = 2;
   localparam int BIT_SUPPLY_UV = 7;
   localparam int BIT_COC_FAULT = 4;
   localparam int BIT_DOC_FAULT = 3;
   localparam int BIT_DISCHARGING = 7;
   localparam int BIT_CHARGING = 6;
   localparam int BIT_REG_ACTIVE = 2;
   localparam int BIT_REG_SLEEP = 1;
   localparam int BIT_PUMP_NRDY = 5;
   localparam int BIT_PUMP_EN = 7;
   localparam int BIT_CHG_FET = 0;
   localparam int BIT_DSG_FET = 1;
   localparam int DELAY_DOC_LSB = 4;
   localparam int DELAY_COC_LSB = 0;
   localparam int DELAY_W = 4;
   // reset values
   localparam logic [7:0] RST_OC_THRESH = 8'hFF;
   localparam logic [7:0] RST_DELAY = 8'h00;
   localparam logic [7:0] RST_SUPPLY_MIN = 8'h00;
   localparam logic [7:0] RST_REG_THRESH = 8'hFF;
   localparam logic RST_CONNECT = 1'b1;
   localparam logic RST_PUMP_EN = 1'b0;
   localparam logic RST_FET = 1'b0;
   // sense code of the current-direction detection level
   localparam logic [7:0] DETECT_LEVEL = 8'h01;
   // timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int SLEEP_CHECK_MS = 256;
   localparam int SLEEP_CHECK_CYCLES_DEF = SLEEP_CHECK_MS * 1000000 / CLK_PERIOD_NS;
   // operating mode, gray along idle -> scan -> low power
   typedef enum logic [1:0] {
      MODE_IDLE = 2'b00,
      MODE_SCAN = 2'b01,
      MODE_LOW_POWER = 2'b11
   } pfd_mode_t;
endpackage

// ---- pfd_pulse_divider.sv ----
`timescale 1ns/1ns
module pfd_pulse_divider import pfd_pkg::*; #(
   parameter int PERIOD = SLEEP_CHECK_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   output logic tick
);
   localparam int W = (PERIOD > 1) ? $clog2(PERIOD) : 1;

   typedef struct packed {
      logic [W-1:0] count;
      logic tick;
   } pfd_div_state_t;

   pfd_div_state_t r;
   pfd_div_state_t next_r;

   ////////////////////////////////////////////////////////////////////////
   // one pulse per period while running; stopping restarts the period
   always_comb begin
      next_r = r;
      next_r.tick = 1'b0;
      if (!run) begin
         next_r.count = '0;
      end else if (r.count == W'(PERIOD - 1)) begin
         next_r.count = '0;
         next_r.tick = 1'b1;
      end else begin
         next_r.count = r.count + W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign tick = r.tick;
endmodule // pfd_pulse_divider

// ---- pfd_scan_debounce.sv ----
`timescale 1ns/1ns
module pfd_scan_debounce import pfd_pkg::*; #(
   parameter int CNT_W = DELAY_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sample,
   input wire logic over,
   input wire logic continuous,
   input wire logic [CNT_W-1:0] limit,
   output logic trip
);
   typedef struct packed {
      logic [CNT_W:0] run;
      logic trip;
   } pfd_deb_state_t;

   pfd_deb_state_t r;
   pfd_deb_state_t next_r;

   ////////////////////////////////////////////////////////////////////////
   // field value n means n+1 consecutive violations; a clean sample restarts
   always_comb begin
      next_r = r;
      next_r.trip = 1'b0;
      if (!continuous) begin
         next_r.run = '0;
         next_r.trip = sample & over;
      end else if (sample) begin
         if (!over) begin
            next_r.run = '0;
         end else if (r.run == {1'b0, limit}) begin
            next_r.run = '0;
            next_r.trip = 1'b1;
         end else begin
            next_r.run = r.run + (CNT_W + 1)'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign trip = r.trip;
endmodule // pfd_scan_debounce

// ---- pfd_fault_detect.sv ----
`timescale 1ns/1ns
module pfd_fault_detect import pfd_pkg::*; #(
   parameter int SLEEP_CHECK_CYCLES = SLEEP_CHECK_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // measurement engine
   input wire pfd_mode_t mode,
   input wire logic continuous_scan,
   input wire logic meas_valid,
   input wire logic meas_is_regulator,
   input wire logic pack_current_negative,
   input wire logic [7:0] pack_current,
   input wire logic [7:0] supply_voltage,
   input wire logic [7:0] regulator_current,
   // power stage and scan control
   output logic charge_transistor,
   output logic discharge_transistor,
   output logic scan_stop,
   output logic charge_pump_not_ready
);
   typedef struct packed {
      logic [7:0] doc_thresh;
      logic [7:0] delay;
      logic [7:0] coc_thresh;
      logic [7:0] supply_min;
      logic [7:0] reg_active_thresh;
      logic [7:0] reg_sleep_thresh;
      logic [7:0] last_regulator;
      logic doc_connect;
      logic coc_connect;
      logic pump_en;
      logic chg_fet;
      logic dsg_fet;
      logic charging;
      logic discharging;
      logic supply_uv;
      logic coc_fault;
      logic doc_fault;
      logic reg_active_fault;
      logic reg_sleep_fault;
      logic pump_nrdy;
      logic scan_stop;
      pfd_mode_t prev_mode;
      logic [DATA_W-1:0] prdata;
   } pfd_state_t;

   pfd_state_t r;
   pfd_state_t next_r;

   ////////////////////////////////////////////////////////////////////////
   // address decode, shared by the read and write paths
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = a[9:2];
      reg_hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:10] == '0) &&
         (i == IDX_OPERATIONS || i == IDX_DOC_THRESH || i == IDX_DELAY ||
          i == IDX_CONNECT || i == IDX_COC_THRESH || i == IDX_SUPPLY_MIN ||
          i == IDX_REG_ACTIVE || i == IDX_REG_SLEEP || i == IDX_PUMP_CTRL ||
          i == IDX_FAULTS || i == IDX_STATUS || i == IDX_INDICATORS ||
          i == IDX_TRANSISTORS);
   endfunction

   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
      reg_index = a[9:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // measurement qualification
   logic in_scan;
   logic in_idle;
   logic in_low_power;
   logic continuous;
   logic pack_sample;
   logic reg_sample;
   logic chg_over;
   logic dsg_over;
   logic coc_trip;
   logic doc_trip;
   logic sleep_tick;
   logic supply_trip;
   logic reg_active_trip;
   logic reg_sleep_trip;
   logic oc_shutoff;
   logic shutoff;
   logic entering_lp;
   logic leaving_lp;
   logic wr;
   logic rd_setup;
   logic clear_faults;
   logic [7:0] widx;
   logic [7:0] wbyte;

   assign in_scan = (mode == MODE_SCAN);
   assign in_idle = (mode == MODE_IDLE);
   assign in_low_power = (mode == MODE_LOW_POWER);
   assign continuous = in_scan & continuous_scan;
   assign pack_sample = meas_valid & ~meas_is_regulator;
   assign reg_sample = meas_valid & meas_is_regulator;
   // comparisons against the programmed thresholds
   assign chg_over = pack_sample & ~pack_current_negative & (pack_current > r.coc_thresh);
   assign dsg_over = pack_sample & pack_current_negative & (pack_current > r.doc_thresh);
   assign supply_trip = reg_sample & (supply_voltage < r.supply_min);
   assign reg_active_trip = reg_sample & (in_scan | in_idle) &
      (regulator_current > r.reg_active_thresh);
   // sleep threshold checked on any regulator sample in low power and on the periodic check
   assign reg_sleep_trip = in_low_power &
      ((reg_sample & (regulator_current > r.reg_sleep_thresh)) |
       (sleep_tick & (r.last_regulator > r.reg_sleep_thresh)));
   assign oc_shutoff = in_scan & ((coc_trip & r.coc_connect) | (doc_trip & r.doc_connect));
   assign shutoff = oc_shutoff | supply_trip | reg_active_trip;
   assign entering_lp = in_low_power & (r.prev_mode != MODE_LOW_POWER);
   assign leaving_lp = in_idle & (r.prev_mode == MODE_LOW_POWER);

   // apb: zero wait states, read data captured in the setup cycle
   assign wr = psel & penable & pwrite & reg_hit(paddr);
   assign rd_setup = psel & ~penable & ~pwrite;
   assign widx = reg_index(paddr);
   assign wbyte = pwdata[7:0];
   assign clear_faults = wr & (widx == IDX_OPERATIONS) & wbyte[BIT_CLEAR_FAULTS];

   ////////////////////////////////////////////////////////////////////////
   // consecutive-violation counters; the delay nibbles pick the counts
   pfd_scan_debounce #(
      .CNT_W(DELAY_W)
   ) u_coc_debounce (
      .clk(clk),
      .rst_n(rst_n),
      .sample(pack_sample),
      .over(chg_over),
      .continuous(continuous),
      .limit(r.delay[DELAY_COC_LSB +: DELAY_W]),
      .trip(coc_trip)
   );

   pfd_scan_debounce #(
      .CNT_W(DELAY_W)
   ) u_doc_debounce (
      .clk(clk),
      .rst_n(rst_n),
      .sample(pack_sample),
      .over(dsg_over),
      .continuous(continuous),
      .limit(r.delay[DELAY_DOC_LSB +: DELAY_W]),
      .trip(doc_trip)
   );

   // periodic sleep check; runs only in low power so the first check is one period in
   pfd_pulse_divider #(
      .PERIOD(SLEEP_CHECK_CYCLES)
   ) u_sleep_check (
      .clk(clk),
      .rst_n(rst_n),
      .run(in_low_power),
      .tick(sleep_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state: registers, sticky faults, indicators and transistor control
   always_comb begin
      next_r = r;
      next_r.prev_mode = mode;
      next_r.scan_stop = continuous & (coc_trip | doc_trip | supply_trip | reg_active_trip);
      if (reg_sample) begin
         next_r.last_regulator = regulator_current;
      end
      // software writes
      if (wr) begin
         unique case (widx)
            IDX_DOC_THRESH: next_r.doc_thresh = wbyte;
            IDX_DELAY: next_r.delay = wbyte;
            IDX_COC_THRESH: next_r.coc_thresh = wbyte;
            IDX_SUPPLY_MIN: next_r.supply_min = wbyte;
            IDX_REG_ACTIVE: next_r.reg_active_thresh = wbyte;
            IDX_REG_SLEEP: next_r.reg_sleep_thresh = wbyte;
            IDX_CONNECT: begin
               next_r.doc_connect = wbyte[BIT_DOC_CONNECT];
               next_r.coc_connect = wbyte[BIT_COC_CONNECT];
            end
            IDX_PUMP_CTRL: next_r.pump_en = wbyte[BIT_PUMP_EN];
            IDX_TRANSISTORS: begin
               next_r.chg_fet = wbyte[BIT_CHG_FET];
               next_r.dsg_fet = wbyte[BIT_DSG_FET];
            end
            default: ; // status registers and the clear strobe are not storage
         endcase
      end
      // direction indicators follow each pack sample taken in scan mode
      if (pack_sample & in_scan) begin
         next_r.charging = ~pack_current_negative & (pack_current > DETECT_LEVEL);
         next_r.discharging = pack_current_negative & (pack_current > DETECT_LEVEL);
      end
      // sticky faults: a trip in the clearing cycle still lands
      next_r.coc_fault = (r.coc_fault & ~clear_faults) | coc_trip;
      next_r.doc_fault = (r.doc_fault & ~clear_faults) | doc_trip;
      next_r.supply_uv = (r.supply_uv & ~clear_faults) | supply_trip;
      next_r.reg_active_fault = (r.reg_active_fault & ~clear_faults) | reg_active_trip;
      next_r.reg_sleep_fault = (r.reg_sleep_fault & ~clear_faults) | reg_sleep_trip;
      // charge pump readiness across low-power entry and exit
      if (entering_lp & r.pump_en) begin
         next_r.pump_nrdy = 1'b1;
      end else if (leaving_lp) begin
         next_r.pump_nrdy = 1'b0;
      end
      // restore on exit from low power; a fault switch-off beats any turn-on
      if (leaving_lp) begin
         next_r.chg_fet = 1'b1;
         next_r.dsg_fet = 1'b1;
      end
      if (shutoff) begin
         next_r.chg_fet = 1'b0;
         next_r.dsg_fet = 1'b0;
      end
      // read data, latched in the setup cycle so it comes from a flop
      if (rd_setup) begin
         next_r.prdata = '0;
         if (reg_hit(paddr)) begin
            unique case (widx)
               IDX_DOC_THRESH: next_r.prdata[7:0] = r.doc_thresh;
               IDX_DELAY: next_r.prdata[7:0] = r.delay;
               IDX_COC_THRESH: next_r.prdata[7:0] = r.coc_thresh;
               IDX_SUPPLY_MIN: next_r.prdata[7:0] = r.supply_min;
               IDX_REG_ACTIVE: next_r.prdata[7:0] = r.reg_active_thresh;
               IDX_REG_SLEEP: next_r.prdata[7:0] = r.reg_sleep_thresh;
               IDX_CONNECT: begin
                  next_r.prdata[BIT_DOC_CONNECT] = r.doc_connect;
                  next_r.prdata[BIT_COC_CONNECT] = r.coc_connect;
               end
               IDX_PUMP_CTRL: next_r.prdata[BIT_PUMP_EN] = r.pump_en;
               IDX_FAULTS: begin
                  next_r.prdata[BIT_SUPPLY_UV] = r.supply_uv;
                  next_r.prdata[BIT_COC_FAULT] = r.coc_fault;
                  next_r.prdata[BIT_DOC_FAULT] = r.doc_fault;
               end
               IDX_STATUS: next_r.prdata[BIT_PUMP_NRDY] = r.pump_nrdy;
               IDX_INDICATORS: begin
                  next_r.prdata[BIT_DISCHARGING] = r.discharging;
                  next_r.prdata[BIT_CHARGING] = r.charging;
                  next_r.prdata[BIT_REG_ACTIVE] = r.reg_active_fault;
                  next_r.prdata[BIT_REG_SLEEP] = r.reg_sleep_fault;
               end
               IDX_TRANSISTORS: begin
                  next_r.prdata[BIT_CHG_FET] = r.chg_fet;
                  next_r.prdata[BIT_DSG_FET] = r.dsg_fet;
               end
               default: ; // operations register reads as zero
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= '0;
         r.doc_thresh <= RST_OC_THRESH;
         r.coc_thresh <= RST_OC_THRESH;
         r.delay <= RST_DELAY;
         r.supply_min <= RST_SUPPLY_MIN;
         r.reg_active_thresh <= RST_REG_THRESH;
         r.reg_sleep_thresh <= RST_REG_THRESH;
         r.doc_connect <= RST_CONNECT;
         r.coc_connect <= RST_CONNECT;
         r.pump_en <= RST_PUMP_EN;
         r.chg_fet <= RST_FET;
         r.dsg_fet <= RST_FET;
         r.prev_mode <= MODE_IDLE;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata = r.prdata;
   assign pready = 1'b1; // never stalls; keeps the bus trivially safe
   assign pslverr = psel & penable & ~reg_hit(paddr);
   assign charge_transistor = r.chg_fet;
   assign discharge_transistor = r.dsg_fet;
   assign scan_stop = r.scan_stop;
   assign charge_pump_not_ready = r.pump_nrdy;

   ////////////////////////////////////////////////////////////////////////
   // checks
   // independent count of consecutive charge violations, so an early trip is visible
   logic [DELAY_W:0] chk_coc_run;
   always_ff @(posedge clk) begin
      if (!rst_n || !continuous) begin
         chk_coc_run <= '0;
      end else if (pack_sample) begin
         if (chg_over && chk_coc_run != {1'b0, r.delay[DELAY_COC_LSB +: DELAY_W]}) begin
            chk_coc_run <= chk_coc_run + (DELAY_W + 1)'(1);
         end else begin
            chk_coc_run <= '0;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_charge_indicator: assert property (
      (pack_sample && in_scan && !pack_current_negative && pack_current > DETECT_LEVEL)
      |=> r.charging) else $error("charging indicator not set");
   a_discharge_indicator: assert property (
      (pack_sample && in_scan && pack_current_negative && pack_current > DETECT_LEVEL)
      |=> r.discharging) else $error("discharging indicator not set");
   a_coc_single_shot: assert property (
      (chg_over && !continuous) |=> ##1 r.coc_fault) else $error("single violation missed");
   a_coc_has_cause: assert property (
      $rose(r.coc_fault) |-> $past(chg_over, 2)) else $error("charge fault without violation");
   a_doc_has_cause: assert property (
      $rose(r.doc_fault) |-> $past(dsg_over, 2)) else $error("discharge fault without violation");
   a_coc_debounce: assert property (
      (continuous && pack_sample && chg_over &&
       chk_coc_run < {1'b0, r.delay[DELAY_COC_LSB +: DELAY_W]})
      |=> !coc_trip) else $error("debounce tripped before the programmed count");
   a_oc_switch_off: assert property (
      (in_scan && ((coc_trip && r.coc_connect) || (doc_trip && r.doc_connect)))
      |=> !charge_transistor && !discharge_transistor) else $error("overcurrent kept power on");
   a_idle_oc_keeps: assert property (
      (in_idle && coc_trip && !supply_trip && !reg_active_trip && !wr && r.chg_fet)
      |=> charge_transistor) else $error("idle overcurrent switched off");
   a_supply_uv: assert property (
      supply_trip |=> r.supply_uv && !charge_transistor && !discharge_transistor)
      else $error("supply undervoltage not handled");
   a_reg_active: assert property (
      reg_active_trip |=> r.reg_active_fault && !charge_transistor)
      else $error("regulator active fault not handled");
   a_sleep_idle_quiet: assert property (
      (in_idle && !r.reg_sleep_fault) |=> !r.reg_sleep_fault)
      else $error("sleep fault raised outside low power");
   a_sleep_check: assert property (
      (sleep_tick && in_low_power && r.last_regulator > r.reg_sleep_thresh)
      |=> r.reg_sleep_fault) else $error("sleep check missed");
   a_pump_not_ready: assert property (
      (entering_lp && r.pump_en) |=> charge_pump_not_ready) else $error("pump flag not set");
   a_lp_exit: assert property (
      (leaving_lp && !shutoff) |=> !charge_pump_not_ready && charge_transistor &&
      discharge_transistor) else $error("low power exit not restored");
   a_fault_clear: assert property (
      (clear_faults && !coc_trip && !supply_trip) |=> !r.coc_fault && !r.supply_uv)
      else $error("faults not cleared");

   c_debounced_trip: cover property (continuous ##1 coc_trip ##1 scan_stop);
   c_supply_trip: cover property (supply_trip ##1 !charge_transistor);
   c_sleep_fault: cover property (entering_lp ##[1:1000] $rose(r.reg_sleep_fault));
   c_lp_restore: cover property (leaving_lp ##1 charge_transistor);
endmodule // pfd_fault_detect

// ---- pfd_host.sv ----
`timescale 1ns/1ns
module pfd_host import pfd_pkg::*; (
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [ADDR_W-1:0] paddr,
   output logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // bus idle at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one transfer; entered just after a rising edge, held until pready is seen high
   task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
      output logic [7:0] q, output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'h0, i, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // clear the sticky faults first, then switch both transistors back on
   task automatic recover();
      logic [7:0] q;
      logic e;
      xfer(1'b1, IDX_OPERATIONS, 8'h02, q, e);
      xfer(1'b1, IDX_TRANSISTORS, 8'h03, q, e);
   endtask
endmodule // pfd_host

// ---- pfd_fault_detect_tb_top.sv ----
`timescale 1ns/1ns
`define CHK(nm, x, g) begin compares++; if ((g) !== (x)) begin n_mismatch++; \
   $display("Error %s expected %0h seen %0h", nm, x, g); end end
module pfd_fault_detect_tb_top import pfd_pkg::*;;
   localparam int SLP = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, chg, dsg, stop, nrdy, e;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   pfd_mode_t mode = MODE_IDLE;
   logic cont = 1'b0, mv = 1'b0, mreg = 1'b0, neg = 1'b0;
   logic [7:0] pc = 8'h00, sv = 8'hFF, rc = 8'h00, q, t;
   int n_mismatch = 0, compares = 0, cyc = 0, n_stop = 0, s0 = 0;
   pfd_fault_detect #(.SLEEP_CHECK_CYCLES(SLP)) u_pfd_fault_detect (.clk(clk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode(mode), .continuous_scan(cont),
      .meas_valid(mv), .meas_is_regulator(mreg), .pack_current_negative(neg), .pack_current(pc),
      .supply_voltage(sv), .regulator_current(rc), .charge_transistor(chg),
      .discharge_transistor(dsg), .scan_stop(stop), .charge_pump_not_ready(nrdy));
   pfd_host u_pfd_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   ////////////////////////////////////////////////////////////////////////////////
   // clock, timeout, and a count of one-cycle stop pulses (one driver only)
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (scan_stop_hit()) n_stop <= n_stop + 1;
      if (cyc == 6000) begin
         n_mismatch++;
         end_sim();
      end
   end
   function automatic logic scan_stop_hit();
      return stop === 1'b1;
   endfunction
   task automatic end_sim();
      if (n_mismatch == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      u_pfd_host.xfer(1'b1, i, d, q, e);
   endtask
   task automatic chk_bit(input logic [7:0] i, input int b, input logic x);
      u_pfd_host.xfer(1'b0, i, 8'h00, q, e);
      `CHK("register bit", x, q[b])
   endtask
   // one sample pulse, then a quiet cycle so the strobe is never driven twice at an edge
   task automatic meas(input logic r, input logic ng, input logic [7:0] v, input logic [7:0] s);
      mv <= 1'b1;
      mreg <= r;
      neg <= ng;
      pc <= v;
      rc <= v;
      sv <= s;
      @(posedge clk);
      mv <= 1'b0;
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h740ce5d2));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk_bit(IDX_DELAY, 0, 1'b0);
      u_pfd_host.xfer(1'b0, 8'h50, 8'h00, q, e);
      `CHK("unmapped error", 1'b1, e)
      wr(IDX_TRANSISTORS, 8'h03);
      // charge then discharge overcurrent: single trip in idle, debounced trip in scan
      for (int k = 0; k < 2; k++) begin
         t = 8'($urandom_range(8'hF0, 8'h10));
         wr(k ? IDX_DOC_THRESH : IDX_COC_THRESH, t);
         meas(1'b0, k[0], t, 8'hFF);
         chk_bit(IDX_FAULTS, 4 - k, 1'b0);
         meas(1'b0, k[0], t + 8'h01, 8'hFF);
         chk_bit(IDX_FAULTS, 4 - k, 1'b1);
         `CHK("fets idle", 2'h3, {dsg, chg})
         u_pfd_host.recover();
         wr(IDX_DELAY, 8'h44);
         mode <= MODE_SCAN;
         cont <= 1'b1;
         s0 = n_stop;
         repeat (4) meas(1'b0, k[0], t + 8'h01, 8'hFF);
         chk_bit(IDX_FAULTS, 4 - k, 1'b0);
         meas(1'b0, k[0], t + 8'h01, 8'hFF);
         @(posedge clk);
         `CHK("fets scan", 2'h0, {dsg, chg})
         chk_bit(IDX_FAULTS, 4 - k, 1'b1);
         `CHK("scan stop", 1'b1, n_stop > s0)
         chk_bit(IDX_INDICATORS, 6 + k, 1'b1);
         chk_bit(IDX_INDICATORS, 7 - k, 1'b0);
         mode <= MODE_IDLE;
         cont <= 1'b0;
         u_pfd_host.recover();
      end
      // supply undervoltage during a continuous scan
      t = 8'($urandom_range(8'hF0, 8'h10));
      wr(IDX_SUPPLY_MIN, t);
      mode <= MODE_SCAN;
      cont <= 1'b1;
      s0 = n_stop;
      meas(1'b1, 1'b0, 8'h00, t - 8'h01);
      `CHK("fets uv", 2'h0, {dsg, chg})
      chk_bit(IDX_FAULTS, 7, 1'b1);
      `CHK("uv stop", 1'b1, n_stop > s0)
      mode <= MODE_IDLE;
      cont <= 1'b0;
      wr(IDX_SUPPLY_MIN, 8'h00);
      u_pfd_host.recover();
      // active regulator limit in idle
      wr(IDX_REG_ACTIVE, t);
      meas(1'b1, 1'b0, t + 8'h01, 8'hFF);
      `CHK("fets reg", 2'h0, {dsg, chg})
      chk_bit(IDX_INDICATORS, 2, 1'b1);
      wr(IDX_REG_ACTIVE, 8'hFF);
      u_pfd_host.recover();
      // sleep limit ignored in idle, checked after low-power entry
      wr(IDX_REG_SLEEP, t);
      meas(1'b1, 1'b0, t + 8'h01, 8'hFF);
      chk_bit(IDX_INDICATORS, 1, 1'b0);
      wr(IDX_PUMP_CTRL, 8'h80);
      wr(IDX_TRANSISTORS, 8'h00);
      mode <= MODE_LOW_POWER;
      repeat (2) @(posedge clk);
      `CHK("not ready", 1'b1, nrdy)
      repeat (SLP + 4) @(posedge clk);
      chk_bit(IDX_INDICATORS, 1, 1'b1);
      mode <= MODE_IDLE;
      repeat (2) @(posedge clk);
      `CHK("not ready idle", 1'b0, nrdy)
      `CHK("fets restore", 2'h3, {dsg, chg})
      chk_bit(IDX_INDICATORS, 1, 1'b1);
      u_pfd_host.recover();
      chk_bit(IDX_INDICATORS, 1, 1'b0);
      end_sim();
   end
endmodule // pfd_fault_detect_tb_top
